// ===== rtl/rtcal_consts.svh
`ifndef RTCAL_CONSTS_SVH
`define RTCAL_CONSTS_SVH

// Register offsets on the internal 4-bit address pointer
`define RTCAL_OFS_WEEKDAY 4'h3
`define RTCAL_OFS_WMIN 4'h8
`define RTCAL_OFS_WHOUR 4'h9
`define RTCAL_OFS_WDAY 4'ha
`define RTCAL_OFS_DMIN 4'hb
`define RTCAL_OFS_DHOUR 4'hc

// Stored field widths
`define RTCAL_MIN_W 7
`define RTCAL_HOUR_W 6
`define RTCAL_DAY_W 7
`define RTCAL_CODE_W 3

// Reset values of the stored fields (contents are undefined after power-up)
`define RTCAL_MIN_RST 7'h00
`define RTCAL_HOUR_RST 6'h00
`define RTCAL_DAY_RST 7'h00
`define RTCAL_CODE_RST 3'h0
`define RTCAL_RDATA_RST 8'h00

// Last legal weekday code before wrapping
`define RTCAL_CODE_LAST 3'h6

`endif

// ===== rtl/rtcal_pkg.sv
package rtcal_pkg;
   typedef logic [7:0] rtcal_byte_t;
   typedef logic [3:0] rtcal_addr_t;
   typedef enum logic {
      RTCAL_ALARM_DAILY,
      RTCAL_ALARM_WEEKLY
   } rtcal_kind_t;
endpackage

// ===== rtl/rtcal_match.sv
`timescale 1ns/1ps
`include "rtcal_consts.svh"

// Combinational time comparator for one alarm
module rtcal_match
   import rtcal_pkg::*;
#(
   parameter rtcal_kind_t KIND = RTCAL_ALARM_DAILY
) (
   input wire logic [`RTCAL_MIN_W-1:0] alarm_min_i,
   input wire logic [`RTCAL_HOUR_W-1:0] alarm_hour_i,
   input wire logic [`RTCAL_DAY_W-1:0] day_mask_i,
   input wire logic [`RTCAL_MIN_W-1:0] cur_min_i,
   input wire logic [`RTCAL_HOUR_W-1:0] cur_hour_i,
   input wire logic [`RTCAL_CODE_W-1:0] cur_code_i,
   output logic match_o
);

   logic time_eq;
   logic day_ok;

   // Raw compare of the hour byte: D5 carries the half-day flag or the
   // tens-of-twenty bit, and the counters use the same coding either way
   assign time_eq = (alarm_min_i == cur_min_i) &&
                    (alarm_hour_i == cur_hour_i);

   // Code 7 is outside the mask, so a weekly alarm never matches on it
   always_comb begin
      day_ok = 1'b1;
      if (KIND == RTCAL_ALARM_WEEKLY) begin
         day_ok = (cur_code_i <= `RTCAL_CODE_LAST) &&
                  day_mask_i[cur_code_i];
      end
   end

   assign match_o = time_eq && day_ok;

endmodule

// ===== rtl/rtcal_alarm_regs.sv
`timescale 1ns/1ps
`include "rtcal_consts.svh"

// Notes on behaviour
// - Weekly minute at 8h keeps a 7-bit BCD minute; bit 7 reads zero.
// - Weekly hour at 9h keeps a 6-bit BCD hour; bits 7 and 6 read zero.
// - Weekly day mask at Ah keeps seven enable bits; bit 7 reads zero.
// - Daily minute at Bh keeps a 7-bit BCD minute; bit 7 reads zero.
// - Daily hour at Ch keeps a 6-bit BCD hour; bits 7 and 6 read zero.
// - Hour bit 5 is the afternoon flag in 12-hour mode, else tens of 20.
// - In 12-hour mode midnight is coded 12 and noon is coded 32.
// - Day mask bit n belongs to weekday code n, codes 0 to 6.
// - With all seven mask bits clear the weekly alarm never matches.
// - Stored alarm bits are undefined after power-up; unused bits read 0.
// - An alarm signals only while current time equals its preset time.
// - Weekday code counts 0 to 6, wraps to 0, and steps on day rollover.
module rtcal_alarm_regs
   import rtcal_pkg::*;
#(
   parameter int DAYS = 7
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [`RTCAL_MIN_W-1:0] cur_min_i,
   input wire logic [`RTCAL_HOUR_W-1:0] cur_hour_i,
   input wire logic day_rollover_i,
   output logic [`RTCAL_CODE_W-1:0] weekday_code_o,
   output logic weekly_match_o,
   output logic daily_match_o
);

   // Elaboration check: the mask is indexed by a 3-bit septimal code
   if (DAYS != `RTCAL_DAY_W) begin : g_bad_days
      $error("rtcal_alarm_regs: DAYS must be 7");
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Address decode, used for both write and read paths
   function automatic logic hit(input rtcal_addr_t a, input rtcal_addr_t o);
      hit = (a == o);
   endfunction

   // Zero-extend a stored field into a bus byte
   function automatic rtcal_byte_t ext7(input logic [6:0] v);
      ext7 = {1'b0, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Alarm storage

   logic [`RTCAL_MIN_W-1:0] wmin_r, wmin_nxt;
   logic [`RTCAL_HOUR_W-1:0] whour_r, whour_nxt;
   logic [`RTCAL_DAY_W-1:0] wday_r, wday_nxt;
   logic [`RTCAL_MIN_W-1:0] dmin_r, dmin_nxt;
   logic [`RTCAL_HOUR_W-1:0] dhour_r, dhour_nxt;

   // Upper bits are never stored, so they cannot read back as ones.
   // Values are not checked: a nonexistent time simply never matches.
   always_comb begin
      wmin_nxt = wmin_r;
      whour_nxt = whour_r;
      wday_nxt = wday_r;
      dmin_nxt = dmin_r;
      dhour_nxt = dhour_r;
      if (reg_wr_i) begin
         if (hit(reg_addr_i, `RTCAL_OFS_WMIN)) begin
            wmin_nxt = reg_wdata_i[`RTCAL_MIN_W-1:0];
         end
         if (hit(reg_addr_i, `RTCAL_OFS_WHOUR)) begin
            whour_nxt = reg_wdata_i[`RTCAL_HOUR_W-1:0];
         end
         if (hit(reg_addr_i, `RTCAL_OFS_WDAY)) begin
            wday_nxt = reg_wdata_i[`RTCAL_DAY_W-1:0];
         end
         if (hit(reg_addr_i, `RTCAL_OFS_DMIN)) begin
            dmin_nxt = reg_wdata_i[`RTCAL_MIN_W-1:0];
         end
         if (hit(reg_addr_i, `RTCAL_OFS_DHOUR)) begin
            dhour_nxt = reg_wdata_i[`RTCAL_HOUR_W-1:0];
         end
      end
   end

   // Contents count as undefined after power-up; zero is just one choice
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wmin_r <= `RTCAL_MIN_RST;
         whour_r <= `RTCAL_HOUR_RST;
         wday_r <= `RTCAL_DAY_RST;
         dmin_r <= `RTCAL_MIN_RST;
         dhour_r <= `RTCAL_HOUR_RST;
      end else begin
         wmin_r <= wmin_nxt;
         whour_r <= whour_nxt;
         wday_r <= wday_nxt;
         dmin_r <= dmin_nxt;
         dhour_r <= dhour_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Weekday counter

   logic [`RTCAL_CODE_W-1:0] code_r, code_nxt;

   // A host write beats a rollover in the same cycle, so the new day sticks
   always_comb begin
      code_nxt = code_r;
      if (reg_wr_i && hit(reg_addr_i, `RTCAL_OFS_WEEKDAY)) begin
         code_nxt = reg_wdata_i[`RTCAL_CODE_W-1:0];
      end else if (day_rollover_i) begin
         if (code_r >= `RTCAL_CODE_LAST) begin
            code_nxt = `RTCAL_CODE_RST;
         end else begin
            code_nxt = code_r + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         code_r <= `RTCAL_CODE_RST;
      end else begin
         code_r <= code_nxt;
      end
   end

   assign weekday_code_o = code_r;

   ////////////////////////////////////////////////////////////////////////
   // Read path

   rtcal_byte_t rdata_r, rdata_nxt;

   // Unmapped offsets read zero; data appears the cycle after the strobe
   always_comb begin
      rdata_nxt = rdata_r;
      if (reg_rd_i) begin
         rdata_nxt = `RTCAL_RDATA_RST;
         if (hit(reg_addr_i, `RTCAL_OFS_WEEKDAY)) begin
            rdata_nxt = {5'h00, code_r};
         end
         if (hit(reg_addr_i, `RTCAL_OFS_WMIN)) begin
            rdata_nxt = ext7(wmin_r);
         end
         if (hit(reg_addr_i, `RTCAL_OFS_WHOUR)) begin
            rdata_nxt = {2'h0, whour_r};
         end
         if (hit(reg_addr_i, `RTCAL_OFS_WDAY)) begin
            rdata_nxt = ext7(wday_r);
         end
         if (hit(reg_addr_i, `RTCAL_OFS_DMIN)) begin
            rdata_nxt = ext7(dmin_r);
         end
         if (hit(reg_addr_i, `RTCAL_OFS_DHOUR)) begin
            rdata_nxt = {2'h0, dhour_r};
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_r <= `RTCAL_RDATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Comparators

   logic weekly_hit, daily_hit;
   logic wmatch_r, wmatch_nxt;
   logic dmatch_r, dmatch_nxt;

   rtcal_match #(
      .KIND(RTCAL_ALARM_WEEKLY)
   ) u_weekly (
      .alarm_min_i(wmin_r),
      .alarm_hour_i(whour_r),
      .day_mask_i(wday_r),
      .cur_min_i(cur_min_i),
      .cur_hour_i(cur_hour_i),
      .cur_code_i(code_r),
      .match_o(weekly_hit)
   );

   rtcal_match #(
      .KIND(RTCAL_ALARM_DAILY)
   ) u_daily (
      .alarm_min_i(dmin_r),
      .alarm_hour_i(dhour_r),
      .day_mask_i(wday_r),
      .cur_min_i(cur_min_i),
      .cur_hour_i(cur_hour_i),
      .cur_code_i(code_r),
      .match_o(daily_hit)
   );

   // Registered so the match level is glitch free toward the flag logic
   always_comb begin
      wmatch_nxt = weekly_hit;
      dmatch_nxt = daily_hit;
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wmatch_r <= 1'b0;
         dmatch_r <= 1'b0;
      end else begin
         wmatch_r <= wmatch_nxt;
         dmatch_r <= dmatch_nxt;
      end
   end

   assign weekly_match_o = wmatch_r;
   assign daily_match_o = dmatch_r;

endmodule

// ===== verification/rtcal_alarm_assertions.sv
`timescale 1ns/1ps
module rtcal_alarm_assertions #(
   parameter int DAYS = 7
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic day_rollover_i,
   input wire logic [2:0] weekday_code_o,
   input wire logic [6:0] cur_min_i,
   input wire logic [5:0] cur_hour_i,
   input wire logic weekly_match_o,
   input wire logic daily_match_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // A weekday write wins over a rollover, so it masks the stepping checks
   wire wr3 = reg_wr_i && reg_addr_i == 4'h3;
   sequence s_wmin_wr;
      reg_wr_i && reg_addr_i == 4'h8;
   endsequence
   sequence s_wmin_rd;
      reg_rd_i && !reg_wr_i && reg_addr_i == 4'h8;
   endsequence
   // Shadows of the alarm fields, kept from what the host writes
   logic [6:0] wmin_s, dmin_s, mask_s;
   logic [5:0] whour_s, dhour_s;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wmin_s <= 7'h00;
         dmin_s <= 7'h00;
         mask_s <= 7'h00;
         whour_s <= 6'h00;
         dhour_s <= 6'h00;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            4'h8: wmin_s <= reg_wdata_i[6:0];
            4'h9: whour_s <= reg_wdata_i[5:0];
            4'ha: mask_s <= reg_wdata_i[6:0];
            4'hb: dmin_s <= reg_wdata_i[6:0];
            4'hc: dhour_s <= reg_wdata_i[5:0];
            default: ;
         endcase
      end
   end
   // Expected compare results; code 7 has no mask bit, so never matches
   wire d_eq = dmin_s == cur_min_i && dhour_s == cur_hour_i;
   wire w_eq = wmin_s == cur_min_i && whour_s == cur_hour_i &&
      weekday_code_o != 3'h7 && mask_s[weekday_code_o];
   // Match outputs lag by one edge, so skip the first edge after reset
   sequence s_run;
      rstn_i && $past(rstn_i);
   endsequence
   ////////////////////////////////////////////////////////////
   min_top_zero_a: assert property (
      reg_rd_i && reg_addr_i inside {4'h8, 4'ha, 4'hb} |=> !reg_rdata_o[7])
      else $error("minute or mask top bit read back set");
   hour_top_zero_a: assert property (
      reg_rd_i && reg_addr_i inside {4'h9, 4'hc} |=> reg_rdata_o[7:6] == 2'h0)
      else $error("hour top bits read back set");
   unmapped_zero_a: assert property (
      reg_rd_i && reg_addr_i inside {[4'h0:4'h2], [4'h4:4'h7], [4'hd:4'hf]}
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   wmin_back_a: assert property (
      s_wmin_wr ##1 !reg_wr_i ##1 s_wmin_rd
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h7f))
      else $error("weekly minute readback differs from write");
   rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   wday_step_a: assert property (
      day_rollover_i && !wr3 && weekday_code_o < 3'h6
      |=> weekday_code_o == $past(weekday_code_o) + 3'h1)
      else $error("weekday did not step");
   wday_wrap_a: assert property (
      day_rollover_i && !wr3 && weekday_code_o >= 3'h6
      |=> weekday_code_o == 3'h0) else $error("weekday did not wrap");
   wday_hold_a: assert property (
      !day_rollover_i && !wr3 |=> $stable(weekday_code_o))
      else $error("weekday moved without rollover");
   daily_match_a: assert property (
      s_run |-> daily_match_o == $past(d_eq))
      else $error("daily match differs from alarm compare");
   weekly_match_a: assert property (
      s_run |-> weekly_match_o == $past(w_eq))
      else $error("weekly match differs from alarm compare");
   mask_zero_a: assert property (
      mask_s == 7'h00 |=> !weekly_match_o)
      else $error("weekly match with empty day mask");
endmodule
bind rtcal_alarm_regs rtcal_alarm_assertions #(.DAYS(DAYS)) u_chk (
   .core_clk_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
   .reg_rdata_o, .day_rollover_i, .weekday_code_o, .cur_min_i,
   .cur_hour_i, .weekly_match_o, .daily_match_o);

// ===== verification/rtcal_host_model.sv
`timescale 1ns/1ps
module rtcal_host_model (
   input wire logic core_clk_i,
   input wire logic [7:0] reg_rdata_i,
   output logic [3:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_rd_o
);
   initial begin
      reg_addr_o = 4'hf;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   // Alarm times handed in are legal BCD; only a bit probe uses ff
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      #1;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(posedge core_clk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d; // Stale data must not look valid
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      #1;
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(posedge core_clk_i);
      #1;
      reg_rd_o = 1'b0;
      d = reg_rdata_i;
   endtask
endmodule

// ===== verification/rtc_alarm_compare_registers_test.sv
`timescale 1ns/1ps
module rtc_alarm_compare_registers_test;
   import rtcal_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic roll = 1'b0;
   logic wr, rd, wk, dl;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic [6:0] cur_min = 7'h00;
   logic [5:0] cur_hour = 6'h00;
   logic [2:0] code;
   int fail_count = 0;
   int n_checks = 0;
   rtcal_byte_t v;
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   rtcal_host_model host (.core_clk_i(core_clk), .reg_rdata_i(rdata),
      .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
   rtcal_alarm_regs dut (.core_clk_i(core_clk), .rstn_i(rstn),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .cur_min_i(cur_min), .cur_hour_i(cur_hour),
      .day_rollover_i(roll), .weekday_code_o(code), .weekly_match_o(wk),
      .daily_match_o(dl));
   ////////////////////////////////////////////////////////////
   task automatic chk(input rtcal_byte_t seen, input rtcal_byte_t exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Inputs always move 1 ns after an edge, never on it
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Unstored bits, 12-hour codes, then each weekday mask bit in turn
   initial begin
      settle(2);
      rstn = 1'b1;
      for (int i = 8; i <= 12; i++) begin
         host.wr(4'(i), 8'hff);
         host.rd(4'(i), v);
         chk(v, (i == 9 || i == 12) ? 8'h3f : 8'h7f);
      end
      host.rd(4'h0, v);
      chk(v, 8'h00);
      host.wr(4'hb, 8'h30);
      host.wr(4'hc, 8'h12);
      cur_min = 7'h30;
      cur_hour = 6'h12;
      settle(3);
      chk(8'(dl), 8'h01);
      cur_hour = 6'h32;
      settle(3);
      chk(8'(dl), 8'h00);
      host.wr(4'h8, 8'h59);
      host.wr(4'h9, 8'h23);
      host.wr(4'ha, 8'h00);
      host.wr(4'h3, 8'h00);
      cur_min = 7'h59;
      cur_hour = 6'h23;
      settle(3);
      chk(8'(wk), 8'h00);
      for (int n = 0; n < 7; n++) begin
         host.wr(4'ha, 8'h7f ^ (8'h01 << n));
         settle(3);
         chk(8'(wk), 8'h00);
         host.wr(4'ha, 8'h01 << n);
         settle(3);
         chk(8'(wk), 8'h01);
         chk(8'(code), 8'(n));
         roll = 1'b1;
         settle(1);
         roll = 1'b0;
      end
      settle(1);
      chk(8'(code), 8'h00);
      // Code 7 only by a write: it reads back, never matches, then wraps
      host.wr(4'h3, 8'hff);
      host.rd(4'h3, v);
      chk(v, 8'h07);
      host.wr(4'ha, 8'h7f);
      settle(3);
      chk(8'(wk), 8'h00);
      roll = 1'b1;
      settle(1);
      roll = 1'b0;
      chk(8'(code), 8'h00);
      settle(3);
      chk(8'(wk), 8'h01);
      print_verdict();
   end
endmodule
